// ==== bench/quad_io_read_command_front_end_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module quad_io_read_command_front_end_tb
  import qspi_read_pkg::*;
;
  logic        aclk, aresetn, qe, fourl, addr4, soft_reset, armed, rej;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, mem_data, opc;
  logic [31:0] wdata, rdata, mem_addr, d;
  logic [3:0]  wstrb;
  logic [2:0]  wrap;
  int          err_count, checks_done;
  qspi_link_if link ();
  quad_read_front_end quad_read_front_end_i (.link(link.device), .aclk,
    .aresetn, .quad_lane_enable_bit(qe), .four_lane_command_mode(fourl),
    .addr_4byte_mode(addr4), .soft_reset, .mem_addr, .mem_data,
    .wrap_config_bits(wrap), .continuous_read_armed(armed),
    .data_phase(), .command_rejected(rej), .read_opcode(opc));
  quad_read_host quad_read_host_i (.link(link.host), .aclk, .aresetn,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp(), .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp());
  quad_link_asserts quad_link_asserts_i (.aclk, .aresetn,
    .cs_n(link.cs_n), .sclk(link.sclk), .host_io_oe(link.host_io_oe),
    .dev_io_oe(link.dev_io_oe));
  always #2 aclk = ~aclk;
  always @(posedge aclk) mem_data <= mem_addr[7:0];
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic b;
    b = 0;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
    while (!b) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      b = bvalid;
    end
    bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v);
    logic r;
    r = 0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    while (!r) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      r = rvalid;
      v = rdata;
    end
    rready <= 0;
  endtask
  task automatic frame(input logic [1:0] c, input logic [2:0] f,
                       input logic [31:0] a, input logic [7:0] m, n);
    logic [31:0] s;
    axw(REG_ADDR, a);
    axw(REG_MODE, {24'h0, m});
    axw(REG_LEN, {24'h0, n});
    axw(REG_CTRL, {26'h0, f, c, 1'b1});
    s = 32'h1;
    while (s[0]) axr(REG_STATUS, s);
    repeat (8) @(posedge aclk);
  endtask
  task automatic t_wrap;
    logic [7:0] a;
    for (int s = 0; s < 4; s++) begin
      a = 8'((8 << s) - 2);
      frame(CMD_SET_WRAP, 3'h0, 32'h0, 8'(s << 5), 8'h00);
      chk("wrap", {29'h0, 2'(s), 1'b0}, {29'h0, wrap});
      frame(s[0] ? CMD_WORD : CMD_QUAD_4B, 3'h0, {24'h0, a}, 8'h00, 8'h04);
      axr(REG_DATA, d);
      chk("data", {a, a + 8'h01, 16'h0001}, d);
    end
  endtask
  task automatic t_cont;
    frame(CMD_WORD, 3'h0, 32'h0000_0020, 8'h20, 8'h01);
    chk("armed", 32'h1, {31'h0, armed});
    frame(CMD_WORD, 3'h2, 32'h0000_0040, 8'h20, 8'h04);
    axr(REG_DATA, d);
    chk("data", 32'h4041_4243, d);
    frame(CMD_WORD, 3'h4, 32'h0, 8'hFF, 8'h00);
    chk("armed", 32'h0, {31'h0, armed});
    addr4 <= 1;
    frame(CMD_OCTAL, 3'h1, 32'h0001_0010, 8'h20, 8'h04);
    axr(REG_DATA, d);
    chk("data", 32'h1011_1213, d);
    chk("addr", 32'h1, {16'h0, mem_addr[31:16]});
    chk("armed", 32'h1, {31'h0, armed});
    @(posedge aclk) soft_reset <= 1;
    @(posedge aclk) soft_reset <= 0;
    repeat (4) @(posedge aclk);
    chk("armed", 32'h0, {31'h0, armed});
    chk("wrap", 32'h1, {29'h0, wrap});
    addr4 <= 0;
  endtask
  task automatic t_reject;
    qe <= 0;
    frame(CMD_WORD, 3'h0, 32'h0, 8'h00, 8'h01);
    chk("rej", 32'h1, {31'h0, rej});
    qe <= 1;
    fourl <= 1;
    frame(CMD_OCTAL, 3'h0, 32'h0, 8'h00, 8'h01);
    chk("rej", 32'h1, {31'h0, rej});
    fourl <= 0;
    frame(CMD_QUAD_4B, 3'h0, 32'h0000_00FE, 8'h00, 8'h04);
    chk("rej", 32'h0, {31'h0, rej});
    chk("op", {24'h0, OP_QUAD_READ_4B}, {24'h0, opc});
    axr(REG_DATA, d);
    chk("data", 32'hFEFF_0001, d);
    chk("addr", 32'h1, {24'h0, mem_addr[15:8]});
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {aclk, aresetn, fourl, addr4, soft_reset, qe} = 6'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = {48'h0, 4'hF};
    {err_count, checks_done} = 64'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    repeat (6) @(posedge aclk);
    chk("wrap", 32'h1, {29'h0, wrap});
    t_wrap();
    t_cont();
    t_reject();
    complete_run();
  end
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire

// ==== bench/quad_link_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module quad_link_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_quiet; cs_n [*8]; endsequence
  property p_clash; (host_io_oe & dev_io_oe) == 4'h0; endproperty
  property p_start; $rose(dev_io_oe[0]) |-> !cs_n && host_io_oe == 4'h0;
  endproperty
  property p_fall; $rose(dev_io_oe[0]) |-> !sclk; endproperty
  property p_lanes; dev_io_oe == 4'h0 || dev_io_oe == 4'hF; endproperty
  property p_release; s_quiet |-> dev_io_oe == 4'h0; endproperty
  property p_hold; !cs_n && dev_io_oe == 4'hF |=> dev_io_oe == 4'hF;
  endproperty
  property p_head; $fell(cs_n) |-> (dev_io_oe == 4'h0) [*8]; endproperty
  property p_half; $rose(sclk) |-> sclk [*8]; endproperty
  a_clash: assert property (p_clash) else $error("clash");
  a_start: assert property (p_start) else $error("start");
  a_fall: assert property (p_fall) else $error("fall");
  a_lanes: assert property (p_lanes) else $error("lanes");
  a_release: assert property (p_release) else $error("release");
  a_hold: assert property (p_hold) else $error("hold");
  a_head: assert property (p_head) else $error("head");
  a_half: assert property (p_half) else $error("half");
endmodule
`default_nettype wire

// ==== core/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
  } sync_regs_t;
  sync_regs_t s;
  sync_regs_t n;
  logic [WIDTH-1:0] agree;
  // --------------------------------------------------------------
  // A change counts once the second and third stages agree.
  // --------------------------------------------------------------
  always_comb begin
    n = s;
    agree = ~(s.s2 ^ s.s3);
    n.s1 = pin_in;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.lvl = (agree & s.s3) | (~agree & s.lvl);
    n.rise = n.lvl & ~s.lvl;
    n.fall = ~n.lvl & s.lvl;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= {RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE,
            {WIDTH{1'b0}}, {WIDTH{1'b0}}};
    end else begin
      s <= n;
    end
  end
  assign level = s.lvl;
  assign rise  = s.rise;
  assign fall  = s.fall;
endmodule
`default_nettype wire

// ==== core/quad_read_front_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module quad_read_front_end
  import qspi_read_pkg::*;
(
  qspi_link_if.device     link,
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        quad_lane_enable_bit,
  input  wire logic        four_lane_command_mode,
  input  wire logic        addr_4byte_mode,
  input  wire logic        soft_reset,
  output logic      [31:0] mem_addr,
  input  wire logic [7:0]  mem_data,
  output logic      [2:0]  wrap_config_bits,
  output logic             continuous_read_armed,
  output logic             data_phase,
  output logic             command_rejected,
  output logic      [7:0]  read_opcode
);
  // --------------------------------------------------------------
  // State.
  // --------------------------------------------------------------
  typedef struct packed {
    dev_state_t  state;
    logic [3:0]  cnt;
    logic [31:0] shreg;
    logic [7:0]  opcode;
    logic        cont;
    logic [2:0]  wrap;
    logic [31:0] addr;
    logic        nib_hi;
    logic        rejected;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
  } dev_regs_t;

  dev_regs_t  s;
  dev_regs_t  n;
  logic [5:0] pin_lvl;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;
  logic       cs_n_lvl;
  logic       sclk_rise;
  logic       sclk_fall;
  logic [3:0] io_lvl;

  // --------------------------------------------------------------
  // Link pins enter the clock domain through three stages.
  // --------------------------------------------------------------
  pin_sync #(
    .WIDTH       (6),
    .RESET_VALUE (6'h2F)
  ) u_pins (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  ({link.cs_n, link.sclk, link.io}),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  assign cs_n_lvl  = pin_lvl[5];
  assign sclk_rise = pin_rise[4];
  assign sclk_fall = pin_fall[4];
  assign io_lvl    = pin_lvl[3:0];

  // --------------------------------------------------------------
  // Address step inside a wrap section or straight on.
  // --------------------------------------------------------------
  function automatic logic [31:0] next_read_addr(input logic [31:0] a,
                                                 input logic [2:0]  w,
                                                 input logic        ok);
    logic [31:0] mask;
    mask = (WRAP_MIN_BYTES << w[2:1]) - 32'h0000_0001;
    if (ok && !w[0]) begin
      return (a & ~mask) | ((a + 32'h0000_0001) & mask); // R3
    end
    return a + 32'h0000_0001; // R19
  endfunction

  // --------------------------------------------------------------
  // Command sequencer.
  // --------------------------------------------------------------
  always_comb begin
    logic [7:0]  op;
    logic [31:0] sh4;
    logic [3:0]  dummy;
    op    = {s.shreg[6:0], io_lvl[0]};
    sh4   = {s.shreg[27:0], io_lvl};
    dummy = dummy_clocks(s.opcode);
    n = s;
    if (soft_reset) begin
      n.cont = 1'b0; // R20
      n.wrap = WRAP_RESET; // R18
    end
    if (cs_n_lvl) begin
      n.state = D_IDLE;
      n.io_oe = 4'h0;
    end else begin
      case (s.state)
        D_IDLE: begin
          n.shreg    = '0;
          n.rejected = 1'b0;
          if (four_lane_command_mode) begin
            n.state    = D_IGNORE; // R15
            n.rejected = 1'b1;
          end else if (s.cont && !soft_reset) begin
            n.state = D_ADDR; // R9 R13
            n.cnt   = addr_nibbles(s.opcode, addr_4byte_mode);
          end else begin
            n.state = D_OPCODE; // R10
            n.cnt   = OPCODE_BITS;
          end
        end
        D_OPCODE: begin
          if (sclk_rise) begin
            n.shreg = {s.shreg[30:0], io_lvl[0]};
            n.cnt   = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
              n.opcode = op;
              n.shreg  = '0;
              n.cnt    = addr_nibbles(op, addr_4byte_mode); // R14
              if (op == OP_SET_WRAP) begin
                n.state = D_ADDR; // R17
              end else if ((op == OP_QUAD_READ_4B || op == OP_WORD_QUAD ||
                            op == OP_OCTAL_WORD) && quad_lane_enable_bit) begin
                n.state = D_ADDR; // R6
              end else begin
                n.state    = D_IGNORE;
                n.rejected = 1'b1;
              end
            end
          end
        end
        D_ADDR: begin
          if (sclk_rise) begin
            n.shreg = sh4;
            n.cnt   = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
              n.addr  = sh4; // R14
              n.shreg = '0;
              n.cnt   = MODE_NIBBLES;
              if (s.opcode == OP_SET_WRAP) begin
                n.state = D_WRAP;
              end else begin
                n.state = D_MODE; // R7
              end
            end
          end
        end
        D_MODE: begin
          if (sclk_rise) begin
            n.shreg = sh4;
            n.cnt   = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
              n.cont   = sh4[CONT_SEL_LSB +: 2] == CONT_ARM_CODE; // R7 R9 R10 R13
              n.cnt    = dummy;
              n.nib_hi = 1'b1;
              if (dummy == 4'h0) begin
                n.state = D_DATA; // R12
              end else begin
                n.state = D_DUMMY; // R5 R16
              end
            end
          end
        end
        D_WRAP: begin
          if (sclk_rise) begin
            n.shreg = sh4;
            n.cnt   = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
              n.wrap  = sh4[WRAP_LSB +: 3]; // R4 R17 R1 R2
              n.state = D_IGNORE;
            end
          end
        end
        D_DUMMY: begin
          if (sclk_rise) begin
            n.cnt = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
              n.state = D_DATA;
            end
          end
        end
        D_DATA: begin
          if (sclk_fall) begin
            n.io_oe  = 4'hF;
            n.nib_hi = !s.nib_hi;
            if (s.nib_hi) begin
              n.io_out = mem_data[7:4];
            end else begin
              n.io_out = mem_data[3:0];
              n.addr   = next_read_addr(s.addr, s.wrap,
                                        s.opcode != OP_OCTAL_WORD); // R1 R2
            end
          end
        end
        default: begin
          n.io_oe = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s      <= '0; // R20
      s.wrap <= WRAP_RESET; // R18
    end else begin
      s <= n;
    end
  end

  // --------------------------------------------------------------
  // Outputs.
  // --------------------------------------------------------------
  assign link.dev_io_out       = s.io_out;
  assign link.dev_io_oe        = s.io_oe;
  assign mem_addr              = s.addr;
  assign wrap_config_bits      = s.wrap;
  assign continuous_read_armed = s.cont;
  assign data_phase            = s.state == D_DATA;
  assign command_rejected      = s.rejected;
  assign read_opcode           = s.opcode;
endmodule
`default_nettype wire

// ==== core/quad_read_host.sv ====
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module quad_read_host
  import qspi_read_pkg::*;
#(
  parameter int unsigned SCLK_HALF = SCLK_HALF_CYCLES
) (
  qspi_link_if.host       link,
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp
);
  typedef struct packed {
    host_state_t state;
    logic [7:0]  div;
    logic        sclk;
    logic        cs_n;
    logic [8:0]  cnt;
    logic [31:0] sh;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic [1:0]  cmd;
    logic        four_b;
    logic [31:0] addr;
    logic [7:0]  mode;
    logic [7:0]  len;
    logic [31:0] rx;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } host_regs_t;

  host_regs_t s;
  host_regs_t n;
  logic [3:0] io_lvl;

  pin_sync #(
    .WIDTH       (4),
    .RESET_VALUE (4'hF)
  ) u_io (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (link.io),
    .level   (io_lvl),
    .rise    (),
    .fall    ()
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = val[8*i +: 8];
    end
    return r;
  endfunction

  // --------------------------------------------------------------
  // Register slave and link sequencer.
  // --------------------------------------------------------------
  always_comb begin
    logic        tick;
    logic        start;
    logic        drive;
    logic [31:0] wv;
    logic [7:0]  op;
    logic [3:0]  an;
    logic [31:0] aw;
    logic [8:0]  rd_n;
    tick  = s.state != H_IDLE && s.div == 8'(SCLK_HALF - 1);
    start = 1'b0;
    drive = 1'b0;
    wv    = '0;
    op    = 8'h00;
    an    = 4'h0;
    aw    = '0;
    rd_n  = '0;
    n     = s;
    if (awvalid && awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      n.w_held = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (s.aw_held && s.w_held) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = AXI_OKAY;
      if (s.aw_addr == REG_CTRL) begin
        wv       = merge({26'h000_0000, 1'b0, 1'b0, s.four_b, s.cmd, 1'b0},
                         s.w_data, s.w_strb);
        n.cmd    = wv[CTRL_CMD +: 2];
        n.four_b = wv[CTRL_4B];
        start    = wv[CTRL_START] && s.state == H_IDLE;
      end else if (s.aw_addr == REG_ADDR) begin
        n.addr = merge(s.addr, s.w_data, s.w_strb);
      end else if (s.aw_addr == REG_MODE) begin
        wv     = merge({24'h00_0000, s.mode}, s.w_data, s.w_strb);
        n.mode = wv[7:0];
      end else if (s.aw_addr == REG_LEN) begin
        wv    = merge({24'h00_0000, s.len}, s.w_data, s.w_strb);
        n.len = wv[7:0];
      end else begin
        n.bresp = AXI_SLVERR;
      end
    end
    if (s.bvalid && bready) n.bvalid = 1'b0;
    if (arvalid && arready) begin
      n.rvalid = 1'b1;
      n.rresp  = AXI_OKAY;
      n.rdata  = '0;
      if (araddr == REG_CTRL) begin
        n.rdata[CTRL_CMD +: 2] = s.cmd;
        n.rdata[CTRL_4B]       = s.four_b;
      end else if (araddr == REG_ADDR) begin
        n.rdata = s.addr;
      end else if (araddr == REG_MODE) begin
        n.rdata[7:0] = s.mode;
      end else if (araddr == REG_LEN) begin
        n.rdata[7:0] = s.len;
      end else if (araddr == REG_DATA) begin
        n.rdata = s.rx;
      end else if (araddr == REG_STATUS) begin
        n.rdata[0] = s.state != H_IDLE;
      end else begin
        n.rresp = AXI_SLVERR;
      end
    end
    if (s.rvalid && rready) n.rvalid = 1'b0;
    op = (n.cmd == CMD_QUAD_4B) ? OP_QUAD_READ_4B :
         (n.cmd == CMD_WORD)    ? OP_WORD_QUAD :
         (n.cmd == CMD_OCTAL)   ? OP_OCTAL_WORD : OP_SET_WRAP;
    an   = addr_nibbles(op, n.four_b); // R14
    aw   = (op == OP_SET_WRAP) ? 32'h0000_0000 :
           (an == ADDR_NIBBLES_4B) ? n.addr : {n.addr[23:0], 8'h00};
    rd_n = (s.len == 8'h00) ? 9'h002 : {s.len, 1'b0};
    if (s.state != H_IDLE) n.div = tick ? 8'h00 : s.div + 8'h01;
    if (start) begin
      n.cs_n = 1'b0;
      n.sclk = 1'b0;
      n.div  = 8'h00;
      drive  = 1'b1;
      if (wv[CTRL_EXIT]) begin
        n.state = H_EXIT; // R11
        n.cnt   = {5'h00, n.four_b ? EXIT_CLOCKS_4B : EXIT_CLOCKS_3B};
      end else if (wv[CTRL_SKIP]) begin
        n.state = H_ADDR; // R9 R13
        n.sh    = aw;
        n.cnt   = {5'h00, an};
      end else begin
        n.state = H_OPC;
        n.sh    = {op, 24'h00_0000};
        n.cnt   = {5'h00, OPCODE_BITS};
      end
    end else if (tick && !s.sclk) begin
      n.sclk = 1'b1;
      n.cnt  = s.cnt - 9'h001;
      case (s.state)
        H_OPC: begin
          n.sh = {s.sh[30:0], 1'b0};
          if (s.cnt == 9'h001) begin
            n.state = H_ADDR;
            n.sh    = aw;
            n.cnt   = {5'h00, an};
          end
        end
        H_ADDR: begin
          n.sh = {s.sh[27:0], 4'h0};
          if (s.cnt == 9'h001) begin
            n.state = H_MODE; // R7 R17
            n.sh    = {s.mode, 24'h00_0000};
            n.cnt   = {5'h00, MODE_NIBBLES};
          end
        end
        H_MODE: begin
          n.sh = {s.sh[27:0], 4'h0};
          if (s.cnt == 9'h001) begin
            n.cnt = {5'h00, dummy_clocks(op)};
            if (op == OP_SET_WRAP) begin
              n.state = H_END;
            end else if (dummy_clocks(op) == 4'h0) begin
              n.state = H_DATA; // R12
              n.cnt   = rd_n;
            end else begin
              n.state = H_DUMMY; // R5 R16
            end
          end
        end
        H_DUMMY: begin
          if (s.cnt == 9'h001) begin
            n.state = H_DATA;
            n.cnt   = rd_n;
          end
        end
        H_DATA: begin
          n.rx = {s.rx[27:0], io_lvl};
          if (s.cnt == 9'h001) n.state = H_END;
        end
        H_EXIT: begin
          if (s.cnt == 9'h001) n.state = H_END;
        end
        default: begin
          n.cnt = s.cnt;
        end
      endcase
    end else if (tick) begin
      n.sclk = 1'b0;
      if (s.state == H_END) begin
        n.state = H_IDLE;
        n.cs_n  = 1'b1;
        n.io_oe = 4'h0;
      end else begin
        drive = 1'b1;
      end
    end
    if (drive) begin
      case (n.state)
        H_OPC: begin
          n.io_oe  = 4'h1;
          n.io_out = {3'h7, n.sh[31]};
        end
        H_ADDR, H_MODE: begin
          n.io_oe  = 4'hF;
          n.io_out = n.sh[31:28];
        end
        H_EXIT: begin
          n.io_oe  = 4'h1; // R11
          n.io_out = 4'hF;
        end
        default: begin
          n.io_oe = 4'h0; // R8
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s      <= '0;
      s.cs_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign link.cs_n        = s.cs_n;
  assign link.sclk        = s.sclk;
  assign link.host_io_out = s.io_out;
  assign link.host_io_oe  = s.io_oe;
  assign awready = !s.aw_held && !s.bvalid;
  assign wready  = !s.w_held && !s.bvalid;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;
endmodule
`default_nettype wire

// ==== inc/qspi_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface qspi_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  logic [3:0] io;
  // Lanes nobody drives float high through the pull-ups.
  assign io = (dev_io_oe & dev_io_out)
            | (~dev_io_oe & host_io_oe & host_io_out)
            | (~dev_io_oe & ~host_io_oe);
  modport host (output cs_n, output sclk, output host_io_out,
                output host_io_oe, input io);
  modport device (input cs_n, input sclk, input io,
                  output dev_io_out, output dev_io_oe);
endinterface
`default_nettype wire

// ==== inc/qspi_read_pkg.sv ====
// Notes on behaviour
// R1 - Wrap setup governs later four-byte quad reads.
// R2 - Wrap setup equally governs later word quad reads.
// R3 - Enabled wrap restarts at aligned section start.
// R4 - Three wrap bits: disable bit, two length bits.
// R5 - Word read: even address, two dummy clocks.
// R6 - Quad reads refused without quad lane enable.
// R7 - Eight continuous bits follow address; upper nibble matters.
// R8 - Host releases lanes before first data fall.
// R9 - Select code 10 skips next word read opcode.
// R10 - Any other select code requires full opcode.
// R11 - Host sends ones on lane zero to exit.
// R12 - Octal read: sixteen-aligned address, no dummy clocks.
// R13 - Select code 10 after octal read skips opcode.
// R14 - Four-byte mode takes 32 address bits, else 24.
// R15 - Word reads only outside four-lane command mode.
// R16 - Fast quad read needs four dummy clocks.
// R17 - Wrap setup: opcode, dummy bits, eight wrap bits.
// R18 - Wrap disabled at reset; codes pick 8..64 bytes.
// R19 - Unwrapped reads increment across page boundaries.
// R20 - Reset clears continuous read state.
`default_nettype none
package qspi_read_pkg;
  // --------------------------------------------------------------
  // Command codes and link framing.
  // --------------------------------------------------------------
  localparam logic [7:0] OP_QUAD_READ_4B = 8'hEC;
  localparam logic [7:0] OP_WORD_QUAD    = 8'hE7;
  localparam logic [7:0] OP_OCTAL_WORD   = 8'hE3;
  localparam logic [7:0] OP_SET_WRAP     = 8'h77;
  localparam logic [3:0] DUMMY_QUAD      = 4'h4;
  localparam logic [3:0] DUMMY_WORD      = 4'h2;
  localparam logic [3:0] DUMMY_OCTAL     = 4'h0;
  localparam logic [3:0] OPCODE_BITS     = 4'h8;
  localparam logic [3:0] ADDR_NIBBLES_3B = 4'h6;
  localparam logic [3:0] ADDR_NIBBLES_4B = 4'h8;
  localparam logic [3:0] MODE_NIBBLES    = 4'h2;
  localparam logic [3:0] EXIT_CLOCKS_3B  = 4'h8;
  localparam logic [3:0] EXIT_CLOCKS_4B  = 4'hA;
  localparam logic [1:0] CONT_ARM_CODE   = 2'b10;
  localparam int         CONT_SEL_LSB    = 4;
  localparam int         WRAP_LSB        = 4;
  localparam logic [2:0] WRAP_RESET      = 3'h1;
  localparam logic [31:0] WRAP_MIN_BYTES = 32'h0000_0008;
  // --------------------------------------------------------------
  // Timing.
  // --------------------------------------------------------------
  localparam int unsigned ACLK_PERIOD_NS   = 4;
  localparam int unsigned SCLK_HALF_NS     = 48;
  localparam int unsigned SCLK_HALF_CYCLES =
    (SCLK_HALF_NS + ACLK_PERIOD_NS - 1) / ACLK_PERIOD_NS;
  // --------------------------------------------------------------
  // Controller registers.
  // --------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_MODE   = 8'h08;
  localparam logic [7:0] REG_LEN    = 8'h0C;
  localparam logic [7:0] REG_DATA   = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CTRL_START = 0;
  localparam int CTRL_CMD   = 1;
  localparam int CTRL_4B    = 3;
  localparam int CTRL_SKIP  = 4;
  localparam int CTRL_EXIT  = 5;
  localparam logic [1:0] CMD_QUAD_4B  = 2'h0;
  localparam logic [1:0] CMD_WORD     = 2'h1;
  localparam logic [1:0] CMD_OCTAL    = 2'h2;
  localparam logic [1:0] CMD_SET_WRAP = 2'h3;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // --------------------------------------------------------------
  // States.
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_OPCODE = 3'b001, D_ADDR = 3'b010,
    D_MODE = 3'b011, D_DUMMY = 3'b100, D_DATA = 3'b101,
    D_WRAP = 3'b110, D_IGNORE = 3'b111
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_OPC = 3'b001, H_ADDR = 3'b010,
    H_MODE = 3'b011, H_DUMMY = 3'b100, H_DATA = 3'b101,
    H_EXIT = 3'b110, H_END = 3'b111
  } host_state_t;
  // --------------------------------------------------------------
  // Shared decoding.
  // --------------------------------------------------------------
  function automatic logic [3:0] dummy_clocks(input logic [7:0] op);
    if (op == OP_WORD_QUAD) return DUMMY_WORD; // R5
    if (op == OP_OCTAL_WORD) return DUMMY_OCTAL; // R12
    return DUMMY_QUAD; // R16
  endfunction
  function automatic logic [3:0] addr_nibbles(input logic [7:0] op,
                                              input logic four_byte);
    if (op == OP_QUAD_READ_4B || four_byte) return ADDR_NIBBLES_4B; // R14
    return ADDR_NIBBLES_3B;
  endfunction
endpackage
`default_nettype wire
